// >>> imac_pkg.sv
// constants, operation codes and helpers of the integer multiply-accumulate unit
package imac_pkg;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned CNT_W  = 6;

    // latency and repeat figures in core clock cycles
    localparam logic [CNT_W-1:0] LAT_SHORT   = 6'h03;
    localparam logic [CNT_W-1:0] LAT_LONG    = 6'h04;
    localparam logic [CNT_W-1:0] REP_SHORT   = 6'h02;
    localparam logic [CNT_W-1:0] REP_LONG    = 6'h03;
    localparam logic [CNT_W-1:0] DIV_LAT     = 6'h24;
    localparam logic [CNT_W-1:0] DIV_REP     = 6'h24;
    localparam logic [CNT_W-1:0] STALL_TAIL  = 6'h02;
    localparam logic [CNT_W-1:0] ADD_PROD_EX = 6'h01;
    localparam logic [CNT_W-1:0] CNT_MAX     = 6'h3f;

    // reset values and the divider step count
    localparam logic [DATA_W-1:0] ACC_RST    = 32'h0000_0000;
    localparam logic [1:0]        SYNC_RST   = 2'h0;
    localparam logic [CNT_W-1:0]  CNT_RST    = 6'h00;
    localparam logic [5:0]        DIV_STEPS  = 6'h20;

    typedef enum logic [3:0] {
        op_none,
        op_signed_product_to_acc,
        op_unsigned_product_to_acc,
        op_mul_acc_add_signed,
        op_mul_acc_add_unsigned,
        op_mul_acc_sub_signed,
        op_mul_acc_sub_unsigned,
        op_three_operand_product,
        op_signed_quotient,
        op_unsigned_quotient
    } imac_op_t;

    // operations that treat operands as unsigned
    function automatic logic op_is_unsigned(input imac_op_t op);
        return (op == op_unsigned_product_to_acc) || (op == op_mul_acc_add_unsigned) ||
               (op == op_mul_acc_sub_unsigned) || (op == op_unsigned_quotient);
    endfunction

endpackage : imac_pkg

// >>> imac_div_seq.sv
// iterative restoring divider, one quotient bit per cycle
module imac_div_seq (
    input  wire logic                        clk_sys,
    input  wire logic                        rst_n,
    input  wire logic                        start,
    input  wire logic                        is_signed,
    input  wire logic [imac_pkg::DATA_W-1:0] dividend,
    input  wire logic [imac_pkg::DATA_W-1:0] divisor,
    output logic      [imac_pkg::DATA_W-1:0] quot_ff,
    output logic      [imac_pkg::DATA_W-1:0] rem_ff
);
    import imac_pkg::*;

    logic [DATA_W-1:0] dvs_ff,  nxt_dvs;
    logic [DATA_W:0]   part_ff, nxt_part;
    logic [DATA_W-1:0] nxt_quot, nxt_rem;
    logic [5:0]        step_ff, nxt_step;
    logic              qneg_ff, nxt_qneg;
    logic              rneg_ff, nxt_rneg;
    logic [DATA_W:0]   trial;
    logic              a_neg, b_neg;

    // a step shifts one dividend bit in; the sign fix-up is applied on the last step
    always_comb begin
        nxt_dvs  = dvs_ff;
        nxt_part = part_ff;
        nxt_quot = quot_ff;
        nxt_rem  = rem_ff;
        nxt_step = step_ff;
        nxt_qneg = qneg_ff;
        nxt_rneg = rneg_ff;
        a_neg    = is_signed & dividend[DATA_W-1];
        b_neg    = is_signed & divisor[DATA_W-1];
        trial    = {part_ff[DATA_W-1:0], quot_ff[DATA_W-1]} - {1'b0, dvs_ff};
        if (start) begin
            nxt_quot = a_neg ? (~dividend + 32'h0000_0001) : dividend;
            nxt_dvs  = b_neg ? (~divisor + 32'h0000_0001) : divisor;
            nxt_part = '0;
            nxt_step = DIV_STEPS;
            nxt_qneg = a_neg ^ b_neg;
            nxt_rneg = a_neg;
        end else if (step_ff != 6'h00) begin
            nxt_step = step_ff - 6'h01;
            if (!trial[DATA_W]) begin
                nxt_part = trial;
                nxt_quot = {quot_ff[DATA_W-2:0], 1'b1};
            end else begin
                nxt_part = {part_ff[DATA_W-1:0], quot_ff[DATA_W-1]};
                nxt_quot = {quot_ff[DATA_W-2:0], 1'b0};
            end
            nxt_rem = nxt_part[DATA_W-1:0];
            // divide by zero leaves all-ones quotient and the dividend as remainder
            if (step_ff == 6'h01) begin
                if (qneg_ff && (dvs_ff != '0)) nxt_quot = ~nxt_quot + 32'h0000_0001;
                if (rneg_ff) nxt_rem = ~nxt_rem + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dvs_ff  <= ACC_RST;
            part_ff <= '0;
            quot_ff <= ACC_RST;
            rem_ff  <= ACC_RST;
            step_ff <= 6'h00;
            qneg_ff <= 1'b0;
            rneg_ff <= 1'b0;
        end else begin
            dvs_ff  <= nxt_dvs;
            part_ff <= nxt_part;
            quot_ff <= nxt_quot;
            rem_ff  <= nxt_rem;
            step_ff <= nxt_step;
            qneg_ff <= nxt_qneg;
            rneg_ff <= nxt_rneg;
        end
    end

endmodule // imac_div_seq

// >>> imac_unit.sv
// integer multiply, multiply-accumulate and divide unit with issue interlocks
module imac_unit (
    input  wire logic                        clk_sys,
    input  wire logic                        rstn,
    input  wire logic                        issue_valid,
    input  wire imac_pkg::imac_op_t          issue_op,
    input  wire logic [imac_pkg::DATA_W-1:0] first_source,
    input  wire logic [imac_pkg::DATA_W-1:0] second_source,
    output logic                             issue_ready_ff,
    output logic                             product_ready_ff,
    output logic                             stall_ff,
    output logic                             acc_ready_ff,
    output logic                             prod_wr_ff,
    output logic      [imac_pkg::DATA_W-1:0] prod_data_ff,
    output logic      [imac_pkg::DATA_W-1:0] acc_upper_ff,
    output logic      [imac_pkg::DATA_W-1:0] acc_lower_ff
);
    import imac_pkg::*;

    // reset release: asynchronous assert, two-stage synchronous release
    logic [1:0] rst_sync_ff;
    logic       rst_n;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_sync_ff <= SYNC_RST;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // 64-bit product, operands widened by sign or zero
    function automatic logic [2*DATA_W-1:0] wide_product(
        input logic              uns,
        input logic [DATA_W-1:0] a,
        input logic [DATA_W-1:0] b
    );
        logic [2*DATA_W-1:0] ea;
        logic [2*DATA_W-1:0] eb;
        logic [4*DATA_W-1:0] full;
        ea   = {{DATA_W{~uns & a[DATA_W-1]}}, a};
        eb   = {{DATA_W{~uns & b[DATA_W-1]}}, b};
        full = ea * eb;
        return full[2*DATA_W-1:0];
    endfunction

    // second operand within the short range takes the fast multiply path
    function automatic logic short_operand(input logic uns, input logic [DATA_W-1:0] b);
        if (uns) begin
            return b[DATA_W-1:16] == 16'h0000;
        end
        return (b[DATA_W-1:15] == 17'h00000) || (b[DATA_W-1:15] == 17'h1ffff);
    endfunction

    // state: shadow accumulator holds the newest value except while a divide is pending, which loads both copies at commit; visible copy lags by latency
    logic [DATA_W-1:0] shad_hi_ff,  nxt_shad_hi;
    logic [DATA_W-1:0] shad_lo_ff,  nxt_shad_lo;
    logic [DATA_W-1:0] nxt_acc_hi,  nxt_acc_lo;
    logic [DATA_W-1:0] pend_prod_ff, nxt_pend_prod;
    logic [DATA_W-1:0] nxt_prod_data;
    logic [DATA_W-1:0] drain_data_ff, nxt_drain_data;
    logic              drain_ff,      nxt_drain;
    logic [CNT_W-1:0]  acc_lat_ff,  nxt_acc_lat;
    logic [CNT_W-1:0]  prod_lat_ff, nxt_prod_lat;
    logic [CNT_W-1:0]  since_ff,    nxt_since;
    logic [CNT_W-1:0]  rep_need_ff, nxt_rep_need;
    logic              last_add_ff, nxt_last_add;
    logic              div_pend_ff, nxt_div_pend;
    logic              nxt_issue_ready, nxt_product_ready;
    logic              nxt_stall, nxt_acc_ready, nxt_prod_wr;

    logic                take;
    logic                uns;
    logic                is_short;
    logic                is_div;
    logic [CNT_W-1:0]    lat_sel;
    logic [CNT_W-1:0]    rep_sel;
    logic [2*DATA_W-1:0] prod64;
    logic [2*DATA_W-1:0] acc64;
    logic [2*DATA_W-1:0] acc_res;
    logic [DATA_W-1:0]   div_quot;
    logic [DATA_W-1:0]   div_rem;

    // issue decode; the product must also clear the add-then-product gap
    always_comb begin
        uns      = op_is_unsigned(issue_op);
        is_div   = (issue_op == op_signed_quotient) || (issue_op == op_unsigned_quotient);
        is_short = short_operand(uns, second_source);
        take     = 1'b0;
        if (issue_valid && (issue_op != op_none)) begin
            take = (issue_op == op_three_operand_product) ? product_ready_ff : issue_ready_ff;
        end
        lat_sel = is_short ? LAT_SHORT : LAT_LONG;
        rep_sel = is_short ? REP_SHORT : REP_LONG;
        if (is_div) begin
            lat_sel = DIV_LAT;
            rep_sel = DIV_REP;
        end
        prod64 = wide_product(uns, first_source, second_source);
        acc64  = {shad_hi_ff, shad_lo_ff};
    end

    // accumulate arithmetic; 64-bit sum wraps, no overflow is ever flagged
    always_comb begin
        unique case (issue_op)
            op_mul_acc_add_signed,
            op_mul_acc_add_unsigned: acc_res = acc64 + prod64;
            op_mul_acc_sub_signed,
            op_mul_acc_sub_unsigned: acc_res = acc64 - prod64;
            default:                 acc_res = prod64;
        endcase
    end

    imac_div_seq u_div (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .start     (take && is_div),
        .is_signed (issue_op == op_signed_quotient),
        .dividend  (first_source),
        .divisor   (second_source),
        .quot_ff   (div_quot),
        .rem_ff    (div_rem)
    );

    // counters, shadow and commit of the accumulator and product
    always_comb begin
        nxt_shad_hi   = shad_hi_ff;
        nxt_shad_lo   = shad_lo_ff;
        nxt_acc_hi    = acc_upper_ff;
        nxt_acc_lo    = acc_lower_ff;
        nxt_pend_prod = pend_prod_ff;
        nxt_prod_data = prod_data_ff;
        nxt_rep_need  = rep_need_ff;
        nxt_last_add  = last_add_ff;
        nxt_div_pend  = div_pend_ff;
        nxt_prod_wr   = 1'b0;
        nxt_drain     = 1'b0;
        nxt_drain_data = drain_data_ff;
        nxt_acc_lat   = (acc_lat_ff != CNT_RST) ? acc_lat_ff - 6'h01 : CNT_RST;
        nxt_prod_lat  = (prod_lat_ff != CNT_RST) ? prod_lat_ff - 6'h01 : CNT_RST;
        nxt_since     = (since_ff != CNT_MAX) ? since_ff + 6'h01 : CNT_MAX;

        // completion: both halves move in one edge
        if (acc_lat_ff == 6'h01) begin
            if (div_pend_ff) begin
                nxt_acc_hi   = div_rem;
                nxt_acc_lo   = div_quot;
                nxt_shad_hi  = div_rem;
                nxt_shad_lo  = div_quot;
                nxt_div_pend = 1'b0;
            end else begin
                nxt_acc_hi = shad_hi_ff;
                nxt_acc_lo = shad_lo_ff;
            end
        end
        if (prod_lat_ff == 6'h01) begin
            nxt_prod_wr   = 1'b1;
            nxt_prod_data = pend_prod_ff;
        end
        // an overtaken product still writes on the edge it was due
        if (drain_ff) begin
            nxt_prod_wr   = 1'b1;
            nxt_prod_data = drain_data_ff;
        end

        if (take) begin
            nxt_since    = 6'h01;
            nxt_rep_need = rep_sel;
            nxt_last_add = (issue_op == op_mul_acc_add_signed) ||
                           (issue_op == op_mul_acc_add_unsigned);
            if (issue_op == op_three_operand_product) begin
                // accumulator left as it was; software must treat it as undefined
                nxt_pend_prod = prod64[DATA_W-1:0];
                nxt_prod_lat  = lat_sel;
                // a product issued at the repeat rate reloads the count one edge
                // before the earlier write; park that word so it is not lost
                if (prod_lat_ff == 6'h02) begin
                    nxt_drain      = 1'b1;
                    nxt_drain_data = pend_prod_ff;
                end
            end else if (is_div) begin
                nxt_div_pend = 1'b1;
                nxt_acc_lat  = lat_sel;
            end else begin
                nxt_shad_hi = acc_res[2*DATA_W-1:DATA_W];
                nxt_shad_lo = acc_res[DATA_W-1:0];
                nxt_acc_lat = lat_sel;
            end
        end
    end

    // handshake outputs derived from next counts so they are registered
    always_comb begin
        nxt_issue_ready   = (nxt_since >= nxt_rep_need);
        nxt_product_ready = (nxt_since >= nxt_rep_need + 
                             (nxt_last_add ? ADD_PROD_EX : CNT_RST));
        nxt_acc_ready     = (nxt_acc_lat == CNT_RST);
        // stall covers all but the last two cycles of the product latency
        nxt_stall         = (nxt_prod_lat > STALL_TAIL);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shad_hi_ff       <= ACC_RST;
            shad_lo_ff       <= ACC_RST;
            acc_upper_ff     <= ACC_RST;
            acc_lower_ff     <= ACC_RST;
            pend_prod_ff     <= ACC_RST;
            prod_data_ff     <= ACC_RST;
            drain_ff         <= 1'b0;
            drain_data_ff    <= ACC_RST;
            acc_lat_ff       <= CNT_RST;
            prod_lat_ff      <= CNT_RST;
            since_ff         <= CNT_MAX;
            rep_need_ff      <= CNT_RST;
            last_add_ff      <= 1'b0;
            div_pend_ff      <= 1'b0;
            prod_wr_ff       <= 1'b0;
            issue_ready_ff   <= 1'b0;
            product_ready_ff <= 1'b0;
            acc_ready_ff     <= 1'b0;
            stall_ff         <= 1'b0;
        end else begin
            shad_hi_ff       <= nxt_shad_hi;
            shad_lo_ff       <= nxt_shad_lo;
            acc_upper_ff     <= nxt_acc_hi;
            acc_lower_ff     <= nxt_acc_lo;
            pend_prod_ff     <= nxt_pend_prod;
            prod_data_ff     <= nxt_prod_data;
            drain_ff         <= nxt_drain;
            drain_data_ff    <= nxt_drain_data;
            acc_lat_ff       <= nxt_acc_lat;
            prod_lat_ff      <= nxt_prod_lat;
            since_ff         <= nxt_since;
            rep_need_ff      <= nxt_rep_need;
            last_add_ff      <= nxt_last_add;
            div_pend_ff      <= nxt_div_pend;
            prod_wr_ff       <= nxt_prod_wr;
            issue_ready_ff   <= nxt_issue_ready;
            product_ready_ff <= nxt_product_ready;
            acc_ready_ff     <= nxt_acc_ready;
            stall_ff         <= nxt_stall;
        end
    end

endmodule // imac_unit

// >>> imac_asserts.sv
// port checks of the multiply-accumulate unit, bound to its top module
module imac_asserts (
    input wire logic                        clk_sys,
    input wire logic                        rstn,
    input wire logic                        issue_valid,
    input wire imac_pkg::imac_op_t          issue_op,
    input wire logic [imac_pkg::DATA_W-1:0] second_source,
    input wire logic                        issue_ready_ff,
    input wire logic                        product_ready_ff,
    input wire logic                        stall_ff,
    input wire logic                        acc_ready_ff,
    input wire logic                        prod_wr_ff,
    input wire logic [imac_pkg::DATA_W-1:0] acc_upper_ff,
    input wire logic [imac_pkg::DATA_W-1:0] acc_lower_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    import imac_pkg::*;
    logic tk, is_prod, is_div, is_add, is_uns, short_b;
    // short timing: second operand inside the 16-bit range of its signedness
    assign is_uns = issue_op inside {op_unsigned_product_to_acc, op_mul_acc_add_unsigned,
                                     op_mul_acc_sub_unsigned};
    assign short_b = is_uns ? (second_source[31:16] == 16'h0000) :
                     (second_source[31:15] inside {17'h00000, 17'h1ffff});
    assign is_prod = (issue_op == op_three_operand_product);
    assign is_div = issue_op inside {op_signed_quotient, op_unsigned_quotient};
    assign is_add = issue_op inside {op_mul_acc_add_signed, op_mul_acc_add_unsigned};
    // a request counts only while its own ready flag is up at the edge
    assign tk = issue_valid && (is_prod ? product_ready_ff : (issue_op != op_none) && issue_ready_ff);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    a_stall_short: assert property (tk && is_prod && short_b |=> stall_ff ##1 !stall_ff)
        else $error("short product hold is not one cycle");
    a_stall_long: assert property (tk && is_prod && !short_b |=> stall_ff [*2] ##1 !stall_ff)
        else $error("long product hold is not two cycles");
    a_repeat_short: assert property (tk && !is_div && short_b |=> !issue_ready_ff ##1 issue_ready_ff)
        else $error("short repeat interval wrong");
    a_repeat_long: assert property (tk && !is_div && !short_b |=> !issue_ready_ff [*2] ##1 issue_ready_ff)
        else $error("long repeat interval wrong");
    // a second accumulate-add at the repeat edge restarts the extra gap
    a_add_prod_gap: assert property (tk && is_add && short_b |=> !product_ready_ff [*2]
        ##1 (product_ready_ff || $past(tk)))
        else $error("product after accumulate-add not held one extra cycle");
    a_div_repeat: assert property (tk && is_div |-> ##35 !issue_ready_ff ##1 issue_ready_ff)
        else $error("divide repeat interval wrong");
    // a commit may coincide with a new issue, so ready need not rise with it
    a_acc_together: assert property ($changed({acc_upper_ff, acc_lower_ff})
        |-> !$past(acc_ready_ff))
        else $error("accumulator changed outside a commit");
    a_prod_pulse: assert property (prod_wr_ff |=> !prod_wr_ff)
        else $error("product write pulse longer than one cycle");
endmodule // imac_asserts

bind imac_unit imac_asserts imac_asserts_inst (.clk_sys(clk_sys), .rstn(rstn),
    .issue_valid(issue_valid), .issue_op(issue_op), .second_source(second_source),
    .issue_ready_ff(issue_ready_ff), .product_ready_ff(product_ready_ff), .stall_ff(stall_ff),
    .acc_ready_ff(acc_ready_ff), .prod_wr_ff(prod_wr_ff), .acc_upper_ff(acc_upper_ff),
    .acc_lower_ff(acc_lower_ff));

// >>> imac_pipe.sv
// pipeline model that issues multiply and divide requests to the unit
module imac_pipe (
    input  wire logic                        clk_sys,
    input  wire logic                        issue_ready_ff,
    input  wire logic                        product_ready_ff,
    output logic                             issue_valid,
    output imac_pkg::imac_op_t               issue_op,
    output logic      [imac_pkg::DATA_W-1:0] first_source,
    output logic      [imac_pkg::DATA_W-1:0] second_source
);
    timeunit 1ns;
    timeprecision 1ps;
    import imac_pkg::*;
    int cyc = 0;
    int take_cyc = 0;
    // edge count, so the bench can measure issue spacing
    always @(posedge clk_sys) cyc <= cyc + 1;
    initial begin
        issue_valid = 1'b0;
        issue_op = op_none;
        first_source = 32'h0000_0000;
        second_source = 32'h0000_0000;
    end
    // request held unchanged until its ready flag is seen at a rising edge
    task automatic issue(input imac_op_t op, input logic [31:0] a, input logic [31:0] b);
        logic rdy;
        @(negedge clk_sys);
        issue_valid = 1'b1;
        issue_op = op;
        first_source = a;
        second_source = b;
        do begin
            @(posedge clk_sys);
            rdy = (op == op_three_operand_product) ? product_ready_ff : issue_ready_ff;
        end while (!rdy);
        take_cyc = cyc;
    endtask
    // released operands flip so a stale value is never mistaken for a live one
    task automatic idle();
        @(negedge clk_sys);
        issue_valid = 1'b0;
        issue_op = op_none;
        first_source = ~first_source;
        second_source = ~second_source;
    endtask
endmodule // imac_pipe

// >>> tb.sv
// self-checking bench of the multiply-accumulate unit
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import imac_pkg::*;
    logic              clk_sys = 1'b0;
    logic              rstn = 1'b0;
    logic              issue_valid, issue_ready_ff, product_ready_ff;
    logic              stall_ff, acc_ready_ff, prod_wr_ff;
    imac_op_t          issue_op;
    logic [DATA_W-1:0] first_source, second_source, prod_data_ff, acc_upper_ff, acc_lower_ff;
    int                error_cnt = 0;
    int                samples_checked = 0;
    int                cyc_cnt = 0;
    logic [63:0]       acc_exp = 64'h0;

    imac_unit imac_unit_inst (.clk_sys(clk_sys), .rstn(rstn), .issue_valid(issue_valid),
        .issue_op(issue_op), .first_source(first_source), .second_source(second_source),
        .issue_ready_ff(issue_ready_ff), .product_ready_ff(product_ready_ff),
        .stall_ff(stall_ff), .acc_ready_ff(acc_ready_ff), .prod_wr_ff(prod_wr_ff),
        .prod_data_ff(prod_data_ff), .acc_upper_ff(acc_upper_ff), .acc_lower_ff(acc_lower_ff));
    imac_pipe imac_pipe_inst (.clk_sys(clk_sys), .issue_ready_ff(issue_ready_ff),
        .product_ready_ff(product_ready_ff), .issue_valid(issue_valid), .issue_op(issue_op),
        .first_source(first_source), .second_source(second_source));

    always #5 clk_sys = ~clk_sys;
    // hang guard: the whole run needs well under this many cycles
    always @(posedge clk_sys) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 3000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // bounded wait for the accumulator to settle
    task automatic wait_acc();
        for (int n = 0; n < 60 && acc_ready_ff !== 1'b1; n++) @(negedge clk_sys);
        chk("acc_ready", 64'h1, {63'h0, acc_ready_ff});
    endtask
    // 64-bit accumulator reference; signed forms sign-extend, others zero-extend
    function automatic logic [63:0] acc_next(imac_op_t op, logic [63:0] acc, logic [31:0] a,
                                             logic [31:0] b);
        logic [63:0] p;
        p = (op inside {op_unsigned_product_to_acc, op_mul_acc_add_unsigned, op_mul_acc_sub_unsigned})
            ? {32'h0, a} * {32'h0, b} : {{32{a[31]}}, a} * {{32{b[31]}}, b};
        if (op inside {op_mul_acc_add_signed, op_mul_acc_add_unsigned}) return acc + p;
        if (op inside {op_mul_acc_sub_signed, op_mul_acc_sub_unsigned}) return acc - p;
        return p;
    endfunction
    // every accumulate form, one at a time and then chained back to back
    task automatic t_acc();
        imac_op_t ops [6] = '{op_signed_product_to_acc, op_mul_acc_add_signed,
            op_mul_acc_sub_signed, op_unsigned_product_to_acc, op_mul_acc_add_unsigned,
            op_mul_acc_sub_unsigned};
        logic [31:0] av [6] = '{32'hffff_fffd, 32'h7fff_ffff, 32'hffff_fff9, 32'hffff_ffff,
                                32'hffff_ffff, 32'h0000_0002};
        logic [31:0] bv [6] = '{32'h0000_0005, 32'h8000_0000, 32'hffff_fff7, 32'h0000_ffff,
                                32'hffff_ffff, 32'h0001_0000};
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 6; i++) begin
                imac_pipe_inst.issue(ops[i], av[i], bv[i]);
                acc_exp = acc_next(ops[i], acc_exp, av[i], bv[i]);
                if (k == 0) begin
                    imac_pipe_inst.idle();
                    wait_acc();
                    chk("acc", acc_exp, {acc_upper_ff, acc_lower_ff});
                end
            end
        end
        imac_pipe_inst.idle();
        wait_acc();
        chk("acc_chain", acc_exp, {acc_upper_ff, acc_lower_ff});
        $display("test accumulate done");
    endtask
    // three-operand product: low word written once, hold cycles counted
    task automatic t_prod(input logic [31:0] a, input logic [31:0] b, input int stl);
        logic [31:0] p;
        int n;
        n = 0;
        p = a * b;
        imac_pipe_inst.issue(op_three_operand_product, a, b);
        imac_pipe_inst.idle();
        for (int i = 0; i < 8 && prod_wr_ff !== 1'b1; i++) begin
            if (stall_ff === 1'b1) n++;
            @(negedge clk_sys);
        end
        chk("prod_wr", 64'h1, {63'h0, prod_wr_ff});
        chk("prod_data", {32'h0, p}, {32'h0, prod_data_ff});
        chk("stall_cycles", 64'(stl), 64'(n));
        @(negedge clk_sys);
        chk("prod_wr_end", 64'h0, {63'h0, prod_wr_ff});
        $display("test product done");
    endtask
    // spacing between two back-to-back issues, in edges
    task automatic t_gap(input imac_op_t o1, input logic [31:0] b1, input imac_op_t o2,
                         input logic [31:0] b2, input int gap);
        int c0;
        imac_pipe_inst.issue(o1, 32'h0000_0005, b1);
        c0 = imac_pipe_inst.take_cyc;
        imac_pipe_inst.issue(o2, 32'h0000_0006, b2);
        imac_pipe_inst.idle();
        chk("issue_gap", 64'(gap), 64'(imac_pipe_inst.take_cyc - c0));
        wait_acc();
        $display("test gap done");
    endtask
    // two products at the repeat rate: both low words come out, in order
    task automatic t_prod_pair(input logic [31:0] b);
        logic [31:0] seen [2];
        int n;
        n = 0;
        imac_pipe_inst.issue(op_three_operand_product, 32'h0000_0003, b);
        imac_pipe_inst.issue(op_three_operand_product, 32'h0000_0005, b);
        imac_pipe_inst.idle();
        for (int i = 0; i < 10; i++) begin
            if (prod_wr_ff === 1'b1) begin
                if (n < 2) seen[n] = prod_data_ff;
                n++;
            end
            @(negedge clk_sys);
        end
        chk("prod_pair_cnt", 64'h2, 64'(n));
        chk("prod_pair_first", {32'h0, 32'h3 * b}, {32'h0, seen[0]});
        chk("prod_pair_second", {32'h0, 32'h5 * b}, {32'h0, seen[1]});
        $display("test product pair done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk("ready_after_reset", 64'h3, {62'h0, issue_ready_ff, product_ready_ff});
        chk("acc_after_reset", 64'h0, {acc_upper_ff, acc_lower_ff});
        t_acc();
        t_prod(32'h0001_2345, 32'hffff_8000, 1);
        t_prod(32'h0000_0003, 32'h0000_8000, 2);
        t_prod_pair(32'h0000_0007);
        t_prod_pair(32'h0001_0000);
        t_gap(op_mul_acc_add_signed, 32'h0000_7fff, op_mul_acc_add_signed, 32'h0, 2);
        t_gap(op_signed_product_to_acc, 32'hffff_7fff, op_mul_acc_sub_signed, 32'h0, 3);
        t_gap(op_unsigned_product_to_acc, 32'h0000_ffff, op_mul_acc_add_unsigned, 32'h0, 2);
        t_gap(op_mul_acc_add_unsigned, 32'h0001_0000, op_none, 32'h0, 3);
        t_gap(op_mul_acc_add_signed, 32'h1, op_three_operand_product, 32'h1, 3);
        t_gap(op_mul_acc_add_unsigned, 32'h0001_0000, op_three_operand_product, 32'h1, 4);
        t_gap(op_unsigned_quotient, 32'h7, op_signed_quotient, 32'h7, 36);
        imac_pipe_inst.issue(op_unsigned_quotient, 32'h0000_0064, 32'h0000_0007);
        imac_pipe_inst.idle();
        wait_acc();
        chk("udiv", {32'h0000_0002, 32'h0000_000e}, {acc_upper_ff, acc_lower_ff});
        imac_pipe_inst.issue(op_signed_quotient, 32'hffff_ff9c, 32'h0000_0007);
        imac_pipe_inst.idle();
        wait_acc();
        chk("sdiv", {32'hffff_fffe, 32'hffff_fff2}, {acc_upper_ff, acc_lower_ff});
        $display("test divide done");
        complete_run();
    end
endmodule // tb
